// file: hdl/spw_pkg.sv
// package: selector codes, reset values and carrier structs for the sleep and pin-change wakeup block
package spw_pkg;
	localparam int unsigned NPINS          = 8;
	localparam logic [3:0]  SEL_DIRECTION  = 4'hF;
	localparam logic [3:0]  SEL_EDGE       = 4'hA;
	localparam logic [3:0]  SEL_PENDING    = 4'h9;
	localparam logic [3:0]  SEL_ENABLE     = 4'hB;
	localparam logic [7:0]  ENABLE_RESET   = 8'hFF;
	localparam logic [7:0]  EDGE_RESET     = 8'hFF;
	localparam logic [7:0]  DIR_RESET      = 8'hFF;
	localparam logic [10:0] START_ADDRESS  = 11'h7FF;

	// one port move from the core: selector and working register
	typedef struct packed {
		logic       valid;
		logic [3:0] sel;
		logic [7:0] wdata;
	} spw_move_t;

	// core status flags as seen by the block
	typedef struct packed {
		logic timeout_status_flag;
		logic powerdown_status_flag;
	} spw_status_t;

	localparam spw_status_t STATUS_RESET = '{timeout_status_flag: 1'b1, powerdown_status_flag: 1'b1};

	typedef enum logic [0:0] {
		ST_RUN,
		ST_SLEEP
	} spw_state_t;
endpackage : spw_pkg

// file: hdl/spw_sync.sv
// module: two-flop synchroniser per bit for the port pins
`timescale 1ns/1ps
module spw_sync #(
	parameter int unsigned WIDTH = 8
) (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_b_i,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] stage;
	logic [WIDTH-1:0] next_stage;

	always_comb
	begin
		next_meta  = async_i;
		next_stage = meta;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			meta  <= '0;
			stage <= '0;
		end
		else
		begin
			meta  <= next_meta;
			stage <= next_stage;
		end
	end

	assign sync_o = stage;
endmodule : spw_sync

// file: hdl/spw_wakeup.sv
// module: power-down control and eight-pin change wakeup with indirect register access
// What this block does
// (RL1) power-down only by the sleep instruction
// (RL2) asleep: core halted, watchdog keeps running
// (RL3) sleep with watchdog: clear count, flags updated
// (RL4) wake on watchdog overflow, pin edge, reset
// (RL5) per-pin active-low wakeup enable bits
// (RL6) edge select one falling, zero rising
// (RL7) enable and edge registers reset to all ones
// (RL8) selected edge latches pending until software clears
// (RL9) pin wakeup restarts at highest program address
// (RL10) software clears pending before enabling pins
// (RL11) software order: edges, clear pending, enable
// (RL12) selector picks direction, edge, pending, enable
// (RL13) pending move swaps with working register
// (RL14) software enables pins as last step
// (RL15) enabled pins interrupt running, wake sleeping
// (RL16) software may disable watchdog for low power
// (RL17) pending register doubles as interrupt pending
// (RL18) edge found against previous sampled level
`timescale 1ns/1ps
module spw_wakeup #(
	parameter int unsigned NPINS = spw_pkg::NPINS
) (
	// clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_b_i,
	// core side
	input  wire logic                 sleep_exec_i,
	input  wire logic                 wdt_enable_i,
	input  wire logic                 wdt_overflow_i,
	input  wire spw_pkg::spw_move_t   move_i,
	output logic      [7:0]           move_rdata_o,
	output logic                      move_rvalid_o,
	// power state
	output logic                      core_halt_o,
	output logic                      wdt_clear_o,
	output logic                      pc_load_o,
	output logic      [10:0]          pc_value_o,
	output spw_pkg::spw_status_t      status_o,
	output logic                      pin_irq_o,
	// port pins
	input  wire logic [NPINS-1:0]     port_b_pins_i,
	output logic      [NPINS-1:0]     port_b_dir_o,
	output logic      [NPINS-1:0]     wake_pending_o
);
	logic [NPINS-1:0]     pin_s;
	logic [NPINS-1:0]     pin_prev;
	logic [NPINS-1:0]     next_pin_prev;
	logic                 prev_ok;
	logic                 next_prev_ok;
	logic [NPINS-1:0]     hit;
	logic [NPINS-1:0]     wake_enable_mask;
	logic [NPINS-1:0]     next_wake_enable_mask;
	logic [NPINS-1:0]     wake_edge_select;
	logic [NPINS-1:0]     next_wake_edge_select;
	logic [NPINS-1:0]     wake_pending_flags;
	logic [NPINS-1:0]     next_wake_pending_flags;
	logic [NPINS-1:0]     port_dir;
	logic [NPINS-1:0]     next_port_dir;
	spw_pkg::spw_state_t  state;
	spw_pkg::spw_state_t  next_state;
	spw_pkg::spw_status_t status;
	spw_pkg::spw_status_t next_status;
	logic [7:0]           rdata;
	logic [7:0]           next_rdata;
	logic                 rvalid;
	logic                 next_rvalid;
	logic                 wdt_clr;
	logic                 next_wdt_clr;
	logic                 pc_load;
	logic                 next_pc_load;
	logic                 irq;
	logic                 next_irq;
	logic [10:0]          pc_value;
	logic [10:0]          next_pc_value;

	// pins are asynchronous: two flops before any edge logic reads them
	spw_sync #(
		.WIDTH (NPINS)
	) u_sync (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.async_i (port_b_pins_i),
		.sync_o  (pin_s)
	);

	// edge detection per pin against the last sampled level
	genvar g;
	generate
		for (g = 0; g < NPINS; g++)
		begin : g_edge
			assign hit[g] = prev_ok && !wake_enable_mask[g] &&                                // see (RL5)
				(wake_edge_select[g] ? (pin_prev[g] && !pin_s[g])                                 // see (RL6)
				                     : (!pin_prev[g] && pin_s[g]));                               // see (RL18)
		end
	endgenerate

	always_comb
	begin
		// prev_ok masks the first sample after reset, whose history is unknown
		next_pin_prev           = pin_s;
		next_prev_ok            = 1'b1;
		next_wake_enable_mask   = wake_enable_mask;
		next_wake_edge_select   = wake_edge_select;
		next_port_dir           = port_dir;
		next_wake_pending_flags = wake_pending_flags;
		next_rdata              = rdata;
		next_rvalid             = 1'b0;
		if (move_i.valid && state == spw_pkg::ST_RUN)
		begin
			next_rvalid = 1'b1;
			case (move_i.sel)                                                                   // see (RL12)
				spw_pkg::SEL_DIRECTION: next_port_dir         = move_i.wdata[NPINS-1:0];
				spw_pkg::SEL_EDGE:      next_wake_edge_select = move_i.wdata[NPINS-1:0];
				spw_pkg::SEL_ENABLE:    next_wake_enable_mask = move_i.wdata[NPINS-1:0];
				spw_pkg::SEL_PENDING:
				begin
					next_rdata              = 8'(wake_pending_flags);                         // see (RL13)
					next_wake_pending_flags = move_i.wdata[NPINS-1:0];
				end
				default: next_rvalid = 1'b0;
			endcase
		end
		// a fresh edge wins over a clear in the same cycle
		next_wake_pending_flags = next_wake_pending_flags | hit;                                // see (RL8)
	end

	// shared with the interrupt path: one pending register for both uses
	always_comb
	begin
		next_state   = state;
		next_status  = status;
		next_wdt_clr = 1'b0;
		next_pc_load = 1'b0;
		next_irq     = 1'b0;
		next_pc_value = spw_pkg::START_ADDRESS;
		case (state)
			spw_pkg::ST_RUN:
			begin
				next_irq = |hit;                                                                  // see (RL15), see (RL17)
				if (sleep_exec_i)                                                                 // see (RL1)
				begin
					next_state = spw_pkg::ST_SLEEP;
					next_status.powerdown_status_flag = 1'b0;
					if (wdt_enable_i)
					begin
						next_wdt_clr                      = 1'b1;                               // see (RL3)
						next_status.timeout_status_flag   = 1'b1;
					end
				end
			end
			spw_pkg::ST_SLEEP:
			begin
				// watchdog overflow wins over a pin edge in the same cycle
				if (wdt_overflow_i)                                                               // see (RL4)
				begin
					next_state                      = spw_pkg::ST_RUN;
					next_status.timeout_status_flag = 1'b0;
					next_pc_load                    = 1'b1;
				end
				else if (|hit)
				begin
					next_state   = spw_pkg::ST_RUN;
					next_pc_load = 1'b1;                                                           // see (RL9)
				end
			end
			default: next_state = spw_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			pin_prev           <= '0;
			prev_ok            <= 1'b0;
			wake_enable_mask   <= spw_pkg::ENABLE_RESET;                                        // see (RL7)
			wake_edge_select   <= spw_pkg::EDGE_RESET;
			port_dir           <= spw_pkg::DIR_RESET;
			wake_pending_flags <= '0;
			rdata              <= '0;
			rvalid             <= 1'b0;
			state              <= spw_pkg::ST_RUN;
			status             <= spw_pkg::STATUS_RESET;
			wdt_clr            <= 1'b0;
			pc_load            <= 1'b0;
			irq                <= 1'b0;
			pc_value           <= spw_pkg::START_ADDRESS;
		end
		else
		begin
			pin_prev           <= next_pin_prev;
			prev_ok            <= next_prev_ok;
			wake_enable_mask   <= next_wake_enable_mask;
			wake_edge_select   <= next_wake_edge_select;
			port_dir           <= next_port_dir;
			wake_pending_flags <= next_wake_pending_flags;
			rdata              <= next_rdata;
			rvalid             <= next_rvalid;
			state              <= next_state;
			status             <= next_status;
			wdt_clr            <= next_wdt_clr;
			pc_load            <= next_pc_load;
			irq                <= next_irq;
			pc_value           <= next_pc_value;
		end
	end

	// halt covers everything except the watchdog, which lives outside
	assign core_halt_o    = (state == spw_pkg::ST_SLEEP);                                       // see (RL2)
	assign move_rdata_o   = rdata;
	assign move_rvalid_o  = rvalid;
	assign wdt_clear_o    = wdt_clr;
	assign pc_load_o      = pc_load;
	assign pc_value_o     = pc_value;
	assign status_o       = status;
	assign pin_irq_o      = irq;
	assign port_b_dir_o   = port_dir;
	assign wake_pending_o = wake_pending_flags;
endmodule : spw_wakeup

// file: sim/spw_pins_model.sv
// model: external drivers on the eight port pins
`timescale 1ns/1ps
module spw_pins_model (
	// clock and requested levels
	input  wire logic       mclk_i,
	input  wire logic [7:0] level_i,
	// driven pins
	output logic      [7:0] pins_o
);
	// change away from the sampling edge so the synchroniser sees a clean step
	always @(negedge mclk_i)
		pins_o <= level_i;
endmodule : spw_pins_model

// file: sim/spw_wakeup_props.sv
// checker: port-level properties of the wakeup block
`timescale 1ns/1ps
module spw_wakeup_props #(
	parameter int unsigned NPINS = 8
) (
	input wire logic               mclk_i,
	input wire logic               rst_b_i,
	input wire logic               sleep_exec_i,
	input wire logic               wdt_enable_i,
	input wire logic               wdt_overflow_i,
	input wire spw_pkg::spw_move_t move_i,
	input wire logic [7:0]         move_rdata_o,
	input wire logic               move_rvalid_o,
	input wire logic               core_halt_o,
	input wire logic               wdt_clear_o,
	input wire logic               pc_load_o,
	input wire logic [10:0]        pc_value_o,
	input wire spw_pkg::spw_status_t status_o,
	input wire logic               pin_irq_o,
	input wire logic [NPINS-1:0]   port_b_dir_o,
	input wire logic [NPINS-1:0]   wake_pending_o
);
	logic mv;
	logic swp;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	assign mv = move_i.valid && !core_halt_o;
	assign swp = mv && move_i.sel == spw_pkg::SEL_PENDING;
	a_sleep_only: assert property ($rose(core_halt_o) |-> $past(sleep_exec_i))
		else $error("halt without sleep");
	a_wdt_sleep: assert property (sleep_exec_i && !core_halt_o && wdt_enable_i |=> wdt_clear_o
		&& status_o.timeout_status_flag && !status_o.powerdown_status_flag) else $error("sleep flags");
	a_wdt_wake: assert property (core_halt_o && wdt_overflow_i |=> pc_load_o && !core_halt_o)
		else $error("no watchdog wake");
	a_pc_start: assert property (pc_load_o |-> pc_value_o == spw_pkg::START_ADDRESS && $past(core_halt_o))
		else $error("wrong start address");
	a_swap_old: assert property (swp |=> move_rvalid_o && move_rdata_o == $past(wake_pending_o))
		else $error("swap data");
	a_asleep_move: assert property (core_halt_o && move_i.valid |=> !move_rvalid_o)
		else $error("move while asleep");
	a_pend_hold: assert property (!swp |=> ($past(wake_pending_o) & ~wake_pending_o) == '0)
		else $error("pending lost");
	a_dir_write: assert property (mv && move_i.sel == spw_pkg::SEL_DIRECTION |=>
		port_b_dir_o == $past(move_i.wdata)) else $error("direction write");
	a_irq_pend: assert property (pin_irq_o |-> wake_pending_o != '0)
		else $error("irq without pending");
endmodule : spw_wakeup_props

bind spw_wakeup spw_wakeup_props #(.NPINS(NPINS)) i_spw_wakeup_props (.mclk_i, .rst_b_i, .sleep_exec_i,
	.wdt_enable_i, .wdt_overflow_i, .move_i, .move_rdata_o, .move_rvalid_o, .core_halt_o, .wdt_clear_o,
	.pc_load_o, .pc_value_o, .status_o, .pin_irq_o, .port_b_dir_o, .wake_pending_o);

// file: sim/spw_wakeup_tb.sv
// testbench: directed scenarios for the sleep and pin-change wakeup block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module spw_wakeup_tb;
	logic               mclk_i = 1'b0;
	logic               rst_b_i = 1'b0;
	logic               slp = 1'b0;
	logic               wen = 1'b0;
	logic               ovf = 1'b0;
	spw_pkg::spw_move_t mvi = '0;
	logic [7:0]         lvl = 8'h01;
	logic [7:0]         pins, rdata, dir, pend;
	logic               rvalid, halt, wclr, pcl, irq;
	logic [10:0]        pcv;
	spw_pkg::spw_status_t st;
	int                 err_count = 0;
	int                 n_checks = 0;
	always #2.5 mclk_i = ~mclk_i;
	spw_pins_model i_spw_pins_model (.mclk_i(mclk_i), .level_i(lvl), .pins_o(pins));
	spw_wakeup i_spw_wakeup (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sleep_exec_i(slp), .wdt_enable_i(wen),
		.wdt_overflow_i(ovf), .move_i(mvi), .move_rdata_o(rdata), .move_rvalid_o(rvalid), .core_halt_o(halt),
		.wdt_clear_o(wclr), .pc_load_o(pcl), .pc_value_o(pcv), .status_o(st), .pin_irq_o(irq),
		.port_b_pins_i(pins), .port_b_dir_o(dir), .wake_pending_o(pend));
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic tick(int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : tick
	task automatic mv(logic [3:0] s, logic [7:0] d);
		@(posedge mclk_i);
		mvi <= '{1'b1, s, d};
		@(posedge mclk_i);
		mvi <= '0;
		#1;
	endtask : mv
	task automatic pulse(input bit ov);
		@(posedge mclk_i);
		if (ov)
			ovf <= 1'b1;
		else
			slp <= 1'b1;
		@(posedge mclk_i);
		ovf <= 1'b0;
		slp <= 1'b0;
		#1;
	endtask : pulse
	task automatic wait_hi(input bit pc);
		int i;
		for (i = 0; i < 20 && (pc ? pcl : irq) !== 1'b1; i++)
			tick(1);
		if (i == 20)
		begin
			err_count++;
			$display("wrong value wait for pulse exp 1 got 0");
			end_sim();
		end
	endtask : wait_hi
	task automatic t_reset();
		`CHK("dir", 8'hFF, dir)
		`CHK("pend", 8'h00, pend)
		`CHK("status", 2'b11, st)
		lvl <= 8'h00;
		tick(6);
		`CHK("disabled", 8'h00, pend)
		lvl <= 8'h01;
		tick(6);
		mv(spw_pkg::SEL_PENDING, 8'h00);
		mv(spw_pkg::SEL_ENABLE, 8'hFE);
		lvl <= 8'h00;
		tick(6);
		`CHK("reset edge", 8'h01, pend)
		mv(spw_pkg::SEL_ENABLE, 8'hFF);
		mv(spw_pkg::SEL_PENDING, 8'h00);
		lvl <= 8'h01;
		tick(6);
	endtask : t_reset
	task automatic t_irq();
		mv(spw_pkg::SEL_EDGE, 8'h01);
		mv(spw_pkg::SEL_PENDING, 8'h00);
		mv(spw_pkg::SEL_ENABLE, 8'hFC);
		tick(4);
		`CHK("steady", 8'h00, pend)
		@(posedge mclk_i);
		lvl <= 8'h02;
		wait_hi(1'b0);
		`CHK("pend", 8'h03, pend)
		mv(spw_pkg::SEL_PENDING, 8'h00);
		`CHK("swap", 8'h03, rdata)
		`CHK("swap valid", 1'b1, rvalid)
		lvl <= 8'h01;
		tick(6);
		`CHK("other edge", 8'h00, pend)
	endtask : t_irq
	task automatic t_pin_wake();
		pulse(1'b0);
		`CHK("halt", 1'b1, halt)
		lvl <= 8'h00;
		wait_hi(1'b1);
		`CHK("pc", 11'h7FF, pcv)
		`CHK("awake", 1'b0, halt)
		`CHK("pend", 8'h01, pend)
		mv(spw_pkg::SEL_PENDING, 8'h00);
	endtask : t_pin_wake
	task automatic t_wdt();
		@(posedge mclk_i);
		wen <= 1'b1;
		pulse(1'b0);
		`CHK("wclr", 1'b1, wclr)
		`CHK("status", 2'b10, st)
		mv(spw_pkg::SEL_DIRECTION, 8'h00);
		`CHK("asleep", 8'hFF, dir)
		`CHK("asleep valid", 1'b0, rvalid)
		pulse(1'b1);
		`CHK("pcl", 1'b1, pcl)
		`CHK("awake", 1'b0, halt)
		`CHK("wdt status", 2'b00, st)
	endtask : t_wdt
	task automatic t_sel();
		mv(4'h3, 8'h00);
		`CHK("bad sel", 1'b0, rvalid)
		mv(spw_pkg::SEL_DIRECTION, 8'h5A);
		`CHK("dir", 8'h5A, dir)
	endtask : t_sel
	task automatic t_rst_wake();
		pulse(1'b0);
		`CHK("halt", 1'b1, halt)
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		tick(3);
		`CHK("reset wake", 1'b0, halt)
		`CHK("status", 2'b11, st)
		`CHK("dir", 8'hFF, dir)
		`CHK("pend", 8'h00, pend)
	endtask : t_rst_wake
	initial
	begin
		repeat (12) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		tick(3);
		t_reset();
		t_irq();
		t_pin_wake();
		t_wdt();
		t_sel();
		t_rst_wake();
		end_sim();
	end
endmodule : spw_wakeup_tb
